// ==== common/plrc_pkg.sv ====
// Constants and types for the link request and configuration block.
// Assumes nothing of its surroundings; every design file refers to it.
package plrc_pkg;

  // ----------------------------------------------------------------
  // Link request framing
  // ----------------------------------------------------------------
  localparam int TYPE_W = 3;
  localparam int ADDR_W = 4;
  localparam int REG_W = 8;
  localparam int BODY_W = 12;
  localparam logic [3:0] LEN_BUS = 4'h3;
  localparam logic [3:0] LEN_READ = 4'h4;
  localparam logic [3:0] LEN_WRITE = 4'hc;
  localparam logic [3:0] LEN_ACCEL = 4'h1;

  typedef enum logic [2:0] {
    PLRC_REQ_IMMED = 3'h0,
    PLRC_REQ_ISO = 3'h1,
    PLRC_REQ_PRIO = 3'h2,
    PLRC_REQ_FAIR = 3'h3,
    PLRC_REQ_READ = 3'h4,
    PLRC_REQ_WRITE = 3'h5,
    PLRC_REQ_ACCEL = 3'h6,
    PLRC_REQ_RSVD = 3'h7
  } plrc_req_t;

  // Three-bit speed codes; the two-bit legacy codes land on these.
  localparam logic [2:0] SPD3_S100 = 3'h0;
  localparam logic [2:0] SPD3_S200 = 3'h2;
  localparam logic [2:0] SPD3_S400 = 3'h4;

  // Two-bit node speed encoding.
  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;
  localparam logic [1:0] SPD_ILLEGAL = 2'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_BUS_RESET_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_POWER_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_ENHANCEMENT_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_PAGE_SELECT = 4'h7;
  localparam logic [3:0] ADDR_NODE_SPEED_CONFIG = 4'h8;
  localparam logic [2:0] PAGE_VENDOR_DEP = 3'h7;

  // Field positions.
  localparam int HOLD_BIT = 7;
  localparam int INIT_BIT = 6;
  localparam int GAP_MSB = 5;
  localparam int ACCEL_BIT = 1;
  localparam int CONCAT_BIT = 0;
  localparam int PWR_MSB = 2;
  localparam int PAGE_LSB = 5;
  localparam int NPA_BIT = 7;
  localparam int LSPD_MSB = 1;

  // Reset values.
  localparam logic [5:0] GAP_RST = 6'h00;
  localparam logic [5:0] GAP_FORCED = 6'h3f;
  localparam logic [1:0] LSPD_RST = 2'h2;
  localparam logic [2:0] PAGE_RST = 3'h0;

  // Power class codes.
  localparam logic [2:0] PWR_NONE = 3'h0;
  localparam logic [2:0] PWR_SELF_15W = 3'h1;
  localparam logic [2:0] PWR_SELF_30W = 3'h2;
  localparam logic [2:0] PWR_SELF_45W = 3'h3;
  localparam logic [2:0] PWR_BUS_PHY_3W = 3'h4;
  localparam logic [2:0] PWR_RESERVED = 3'h5;
  localparam logic [2:0] PWR_BUS_LINK_3W = 3'h6;
  localparam logic [2:0] PWR_BUS_LINK_7W = 3'h7;

  // Least hold time of the power-up reset, kept for reference.
  localparam int RESET_MIN_MS = 2;

endpackage

// ==== logic/plrc_lreq_rx.sv ====
// Serial link request receiver: frames the request line into requests.
// Assumes the request line is synchronous to clk, one bit per cycle.
`timescale 1ns/1ps

module plrc_lreq_rx
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic lreq,
  output logic req_valid,
  output plrc_pkg::plrc_req_t req_type,
  output logic [11:0] req_body,
  output logic req_short
);

  // ----------------------------------------------------------------
  // Framing state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLRC_RX_IDLE = 2'b00,
    PLRC_RX_TYPE = 2'b01,
    PLRC_RX_BODY = 2'b11,
    PLRC_RX_STOP = 2'b10
  } plrc_rx_t;

  plrc_rx_t state_r;
  logic [3:0] cnt_r;
  logic [2:0] type_r;
  logic [11:0] body_r;
  logic valid_r;
  logic short_r;
  plrc_pkg::plrc_req_t type_out_r;
  logic [11:0] body_out_r;
  logic [3:0] body_len;
  logic is_bus;

  // Body length follows from the request type.
  function automatic logic [3:0] len_of(input logic [2:0] t);
    if (t == plrc_pkg::PLRC_REQ_READ)
      len_of = plrc_pkg::LEN_READ;
    else if (t == plrc_pkg::PLRC_REQ_WRITE)
      len_of = plrc_pkg::LEN_WRITE;
    else if (t[2] == 1'b0)
      len_of = plrc_pkg::LEN_BUS;
    else
      len_of = plrc_pkg::LEN_ACCEL;
  endfunction

  assign body_len = len_of(type_r);
  assign is_bus = (type_r[2] == 1'b0);

  // Shift in start, type, body and stop; a one where the stop bit of a
  // bus request belongs is the start of the next request.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= PLRC_RX_IDLE;
      cnt_r <= 4'h0;
      type_r <= 3'h0;
      body_r <= 12'h000;
      valid_r <= 1'b0;
      short_r <= 1'b0;
      type_out_r <= plrc_pkg::PLRC_REQ_IMMED;
      body_out_r <= 12'h000;
    end
    else if (ce)
    begin
      valid_r <= 1'b0;
      case (state_r)
        PLRC_RX_IDLE:
        begin
          cnt_r <= 4'h0;
          if (lreq)
            state_r <= PLRC_RX_TYPE;
        end
        PLRC_RX_TYPE:
        begin
          type_r <= {type_r[1:0], lreq};
          body_r <= 12'h000;
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h2)
          begin
            cnt_r <= 4'h0;
            state_r <= PLRC_RX_BODY;
          end
        end
        PLRC_RX_BODY:
        begin
          body_r <= {body_r[10:0], lreq};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == body_len - 4'h1)
            state_r <= PLRC_RX_STOP;
        end
        default:
        begin
          valid_r <= 1'b1;
          type_out_r <= plrc_pkg::plrc_req_t'(type_r);
          body_out_r <= body_r;
          short_r <= is_bus && lreq;
          cnt_r <= 4'h0;
          state_r <= (is_bus && lreq) ? PLRC_RX_TYPE : PLRC_RX_IDLE;
        end
      endcase
    end
  end

  assign req_valid = valid_r;
  assign req_type = type_out_r;
  assign req_body = body_out_r;
  assign req_short = short_r;

endmodule // plrc_lreq_rx

// ==== logic/plrc_top.sv ====
// Link request handling, register file and self-ID reporting of a
// two-port cable PHY. Assumes a link layer driving the request line
// synchronous to clk, and a PHY core that reports bus resets and
// PHY-config loads and consumes the self-ID and arbitration outputs.
`timescale 1ns/1ps

// How it works
// - Power class is a 3-bit code, from no power to bus-powered link.
// - Power class pins load the self-ID power field after reset; writes win.
// - Bus requests with 2-bit or 3-bit speed codes decode S100-S400 alike.
// - A short bus request followed at once by another frames correctly.
// - A bus request faster than S400 sends a prefix then end, no data.
// - A link request turns arbitration acceleration on or off; it is on from reset once the enable bit is set.
// - Every received packet is passed to the link whatever its speed.
// - Self-ID speed comes from the node speed field of vendor page 7.
// - Peers are always told S400, whatever the node speed field holds.
// - Node speed field powers up at S400; software normally keeps it.
// - Writing one to the initiate bit starts a bus reset and initialization.
// - Initiate bit, root holdoff and gap count share one register write.
// - Node speed is 2 bits, reset to S400, untouched by bus reset.
// - Two bus resets without a gap count write force gap count to 63.
module plrc_top
#(
  parameter int DATA_W = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic lreq,
  input wire logic [2:0] power_class_pins,
  input wire logic bus_reset_event,
  input wire logic phy_config_load,
  input wire logic phy_config_hold,
  input wire logic [5:0] phy_config_gap,
  input wire logic rx_valid,
  input wire logic [DATA_W-1:0] rx_data,
  output logic llc_rx_valid,
  output logic [DATA_W-1:0] llc_rx_data,
  output logic arb_req,
  output plrc_pkg::plrc_req_t arb_type,
  output logic [1:0] arb_speed,
  output logic tx_data_prefix,
  output logic tx_data_end,
  output logic stat_valid,
  output logic [3:0] stat_addr,
  output logic [7:0] stat_data,
  output logic bus_reset_req,
  output logic root_holdoff,
  output logic [5:0] gap_count,
  output logic arbitration_accel_active,
  output logic multispeed_concat_enable,
  output logic null_packet_actions,
  output logic [2:0] selfid_pwr,
  output logic [1:0] selfid_speed,
  output logic [1:0] peer_speed
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (DATA_W < 2 || DATA_W > 8)
    begin : g_bad_width
      $error("plrc_top: DATA_W must lie between 2 and 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Request receiver
  // ----------------------------------------------------------------
  logic req_valid;
  plrc_pkg::plrc_req_t req_type;
  logic [11:0] req_body;
  logic req_short;

  plrc_lreq_rx u_rx
  (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .lreq(lreq),
    .req_valid(req_valid),
    .req_type(req_type),
    .req_body(req_body),
    .req_short(req_short)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLRC_NP_IDLE = 2'b00,
    PLRC_NP_PREFIX = 2'b01,
    PLRC_NP_END = 2'b11
  } plrc_np_t;

  // Speed code of a bus request: the third bit of a short request is its
  // stop bit, which is zero, so legacy codes map onto the 3-bit ones.
  function automatic logic [1:0] spd_of(input logic [2:0] code);
    if (code == plrc_pkg::SPD3_S400)
      spd_of = plrc_pkg::SPD_S400;
    else if (code == plrc_pkg::SPD3_S200)
      spd_of = plrc_pkg::SPD_S200;
    else
      spd_of = plrc_pkg::SPD_S100;
  endfunction

  wire is_bus_req = req_valid && (req_type[2] == 1'b0);
  wire [2:0] spd_code = req_body[2:0];
  wire too_fast = spd_code > plrc_pkg::SPD3_S400;
  wire wr_req = req_valid && (req_type == plrc_pkg::PLRC_REQ_WRITE);
  wire rd_req = req_valid && (req_type == plrc_pkg::PLRC_REQ_READ);
  wire accel_req = req_valid && (req_type == plrc_pkg::PLRC_REQ_ACCEL);
  wire [3:0] wr_addr = req_body[11:8];
  wire [7:0] wr_data = req_body[7:0];
  wire [3:0] rd_addr = req_body[3:0];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic hold_r;
  logic init_r;
  logic [5:0] gap_r;
  logic [2:0] pwr_r;
  logic pwr_load_r;
  logic accel_en_r;
  logic concat_en_r;
  logic [2:0] page_r;
  logic npa_r;
  logic [1:0] lspd_r;
  logic accel_on_r;
  logic reset_no_gap_wr_r;

  wire page7 = (page_r == plrc_pkg::PAGE_VENDOR_DEP);
  wire wr_reg1 = wr_req && (wr_addr == plrc_pkg::ADDR_BUS_RESET_CONTROL);
  wire wr_reg4 = wr_req && (wr_addr == plrc_pkg::ADDR_POWER_CONFIG);
  wire wr_reg5 = wr_req && (wr_addr == plrc_pkg::ADDR_ENHANCEMENT_CONTROL);
  wire wr_reg7 = wr_req && (wr_addr == plrc_pkg::ADDR_PAGE_SELECT);
  wire wr_reg8 = wr_req && page7 &&
    (wr_addr == plrc_pkg::ADDR_NODE_SPEED_CONFIG);
  wire gap_write = wr_reg1 || phy_config_load;

  // Bus reset control: one write carries initiate, holdoff and gap.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hold_r <= 1'b0;
      init_r <= 1'b0;
      gap_r <= plrc_pkg::GAP_RST;
      reset_no_gap_wr_r <= 1'b0;
    end
    else if (ce)
    begin
      if (bus_reset_event)
      begin
        init_r <= 1'b0;
        reset_no_gap_wr_r <= 1'b1;
        if (reset_no_gap_wr_r)
          gap_r <= plrc_pkg::GAP_FORCED;
      end
      if (gap_write && !bus_reset_event)
        reset_no_gap_wr_r <= 1'b0;
      if (phy_config_load)
      begin
        hold_r <= phy_config_hold;
        gap_r <= phy_config_gap;
      end
      if (wr_reg1)
      begin
        hold_r <= wr_data[plrc_pkg::HOLD_BIT];
        gap_r <= wr_data[plrc_pkg::GAP_MSB:0];
        if (wr_data[plrc_pkg::INIT_BIT])
          init_r <= 1'b1;
      end
    end
  end

  // Power class: pins are caught one cycle after reset release, and any
  // later write to the field replaces them.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pwr_r <= plrc_pkg::PWR_NONE;
      pwr_load_r <= 1'b1;
    end
    else if (ce)
    begin
      pwr_load_r <= 1'b0;
      if (wr_reg4)
        pwr_r <= wr_data[plrc_pkg::PWR_MSB:0];
      else if (pwr_load_r)
        pwr_r <= power_class_pins;
    end
  end

  // Enhancement, page select and vendor page fields.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      accel_en_r <= 1'b0;
      concat_en_r <= 1'b0;
      page_r <= plrc_pkg::PAGE_RST;
      npa_r <= 1'b0;
      lspd_r <= plrc_pkg::LSPD_RST;
    end
    else if (ce)
    begin
      if (wr_reg5)
      begin
        accel_en_r <= wr_data[plrc_pkg::ACCEL_BIT];
        concat_en_r <= wr_data[plrc_pkg::CONCAT_BIT];
      end
      if (wr_reg7)
        page_r <= wr_data[7:plrc_pkg::PAGE_LSB];
      if (wr_reg8)
      begin
        npa_r <= wr_data[plrc_pkg::NPA_BIT];
        lspd_r <= wr_data[plrc_pkg::LSPD_MSB:0];
      end
    end
  end

  // Acceleration control request turns acceleration on or off for now.
  always_ff @(posedge clk)
  begin
    if (reset)
      accel_on_r <= 1'b1;
    else if (ce && accel_req)
      accel_on_r <= req_body[0];
  end

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  logic [7:0] rd_value;
  logic stat_valid_r;
  logic [3:0] stat_addr_r;
  logic [7:0] stat_data_r;

  // Register read mux; unmapped and off-page addresses read as zero.
  always_comb
  begin
    rd_value = 8'h00;
    if (rd_addr == plrc_pkg::ADDR_BUS_RESET_CONTROL)
      rd_value = {hold_r, init_r, gap_r};
    else if (rd_addr == plrc_pkg::ADDR_POWER_CONFIG)
      rd_value = {5'h00, pwr_r};
    else if (rd_addr == plrc_pkg::ADDR_ENHANCEMENT_CONTROL)
      rd_value = {6'h00, accel_en_r, concat_en_r};
    else if (rd_addr == plrc_pkg::ADDR_PAGE_SELECT)
      rd_value = {page_r, 5'h00};
    else if (page7 && rd_addr == plrc_pkg::ADDR_NODE_SPEED_CONFIG)
      rd_value = {npa_r, 5'h00, lspd_r};
  end

  // Status answer one cycle after a read request is framed.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stat_valid_r <= 1'b0;
      stat_addr_r <= 4'h0;
      stat_data_r <= 8'h00;
    end
    else if (ce)
    begin
      stat_valid_r <= rd_req;
      if (rd_req)
      begin
        stat_addr_r <= rd_addr;
        stat_data_r <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus requests and null packets
  // ----------------------------------------------------------------
  plrc_np_t np_r;
  logic arb_req_r;
  plrc_pkg::plrc_req_t arb_type_r;
  logic [1:0] arb_speed_r;

  // Legal bus requests go to arbitration; too fast ones send a null
  // packet instead. The short flag needs no handling: both forms decode
  // to the same code.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      arb_req_r <= 1'b0;
      arb_type_r <= plrc_pkg::PLRC_REQ_IMMED;
      arb_speed_r <= plrc_pkg::SPD_S100;
      np_r <= PLRC_NP_IDLE;
    end
    else if (ce)
    begin
      arb_req_r <= is_bus_req && !too_fast;
      if (is_bus_req && !too_fast)
      begin
        arb_type_r <= req_type;
        arb_speed_r <= spd_of(spd_code);
      end
      case (np_r)
        PLRC_NP_IDLE:
          if (is_bus_req && too_fast)
            np_r <= PLRC_NP_PREFIX;
        PLRC_NP_PREFIX:
          np_r <= PLRC_NP_END;
        default:
          np_r <= PLRC_NP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive forwarding
  // ----------------------------------------------------------------
  logic llc_rx_valid_r;
  logic [DATA_W-1:0] llc_rx_data_r;

  // Every received byte goes to the link with no speed filter.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      llc_rx_valid_r <= 1'b0;
      llc_rx_data_r <= '0;
    end
    else if (ce)
    begin
      llc_rx_valid_r <= rx_valid;
      llc_rx_data_r <= rx_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Self-ID fields: the power class code goes out as stored.
  assign selfid_pwr = pwr_r;
  assign selfid_speed = lspd_r;
  assign peer_speed = plrc_pkg::SPD_S400;
  assign arbitration_accel_active = accel_en_r && accel_on_r;
  assign multispeed_concat_enable = concat_en_r;
  assign null_packet_actions = npa_r;
  assign bus_reset_req = init_r;
  assign root_holdoff = hold_r;
  assign gap_count = gap_r;
  assign tx_data_prefix = (np_r == PLRC_NP_PREFIX);
  assign tx_data_end = (np_r == PLRC_NP_END);
  assign arb_req = arb_req_r;
  assign arb_type = arb_type_r;
  assign arb_speed = arb_speed_r;
  assign stat_valid = stat_valid_r;
  assign stat_addr = stat_addr_r;
  assign stat_data = stat_data_r;
  assign llc_rx_valid = llc_rx_valid_r;
  assign llc_rx_data = llc_rx_data_r;

endmodule // plrc_top

// ==== tb/plrc_assertions.sv ====
// Concurrent checks on the ports of the link request block.
// Assumes it is bound into plrc_top and shares its clock and reset.
`timescale 1ns/1ps

module plrc_assertions
#(
  parameter int DATA_W = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [2:0] power_class_pins,
  input wire logic bus_reset_event,
  input wire logic phy_config_load,
  input wire logic phy_config_hold,
  input wire logic [5:0] phy_config_gap,
  input wire logic rx_valid,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic llc_rx_valid,
  input wire logic [DATA_W-1:0] llc_rx_data,
  input wire logic arb_req,
  input wire logic [1:0] arb_speed,
  input wire logic tx_data_prefix,
  input wire logic tx_data_end,
  input wire logic bus_reset_req,
  input wire logic root_holdoff,
  input wire logic [5:0] gap_count,
  input wire logic [2:0] selfid_pwr,
  input wire logic [1:0] peer_speed
);
  // ----------------------------------------------------------------
  // Port checks
  // ----------------------------------------------------------------
  // All checks share the one clock and pause while reset is high.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_peer_s400:
    assert property (peer_speed == 2'h2)
    else $error("peer speed is not S400");
  chk_null_end_next:
    assert property (tx_data_prefix |=> tx_data_end && !tx_data_prefix)
    else $error("null packet end missing");
  chk_end_has_prefix:
    assert property (tx_data_end |-> $past(tx_data_prefix))
    else $error("packet end without prefix");
  chk_null_no_grant:
    assert property (tx_data_prefix |-> !arb_req)
    else $error("too fast request was granted");
  chk_speed_legal:
    assert property (arb_req |-> arb_speed != 2'h3)
    else $error("illegal arbitration speed");
  chk_rx_forward:
    assert property ($past(ce) && !$past(reset) |->
      llc_rx_valid == $past(rx_valid) && llc_rx_data == $past(rx_data))
    else $error("received data not forwarded");
  chk_pwr_straps:
    assert property ($past(reset, 2) && !$past(reset) && $past(ce) |->
      selfid_pwr == $past(power_class_pins))
    else $error("power class straps not loaded");
  chk_init_clear:
    assert property ($fell(bus_reset_req) |-> $past(bus_reset_event))
    else $error("bus reset request dropped early");
  chk_gap_forced:
    assert property ($past(bus_reset_event) && !$past(phy_config_load) &&
      gap_count != $past(gap_count) |-> gap_count == 6'h3f)
    else $error("gap count changed to a wrong value");
  chk_config_load:
    assert property (phy_config_load |=> gap_count == $past(phy_config_gap)
      && root_holdoff == $past(phy_config_hold))
    else $error("configuration load not applied");
endmodule // plrc_assertions

bind plrc_top plrc_assertions #(.DATA_W(DATA_W)) chk (.clk, .reset, .ce,
  .power_class_pins, .bus_reset_event, .phy_config_load, .phy_config_hold,
  .phy_config_gap, .rx_valid, .rx_data, .llc_rx_valid, .llc_rx_data,
  .arb_req, .arb_speed, .tx_data_prefix, .tx_data_end, .bus_reset_req,
  .root_holdoff, .gap_count, .selfid_pwr, .peer_speed);

// ==== tb/plrc_link_model.sv ====
// Link layer side: shifts one serial request frame out on the line.
// Assumes the bench sets go, frame and length at a falling edge.
`timescale 1ns/1ps

module plrc_link_model
(
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] frame,
  input wire logic [5:0] len,
  output logic busy,
  output logic lreq
);
  logic [31:0] sh_r = 32'h0;
  logic [5:0] cnt_r = 6'h00;

  assign busy = cnt_r != 6'h00;

  // Sends the frame MSB first, one bit per cycle, then idles low.
  initial lreq = 1'b0;
  always @(negedge clk)
  begin
    if (cnt_r != 6'h00)
    begin
      lreq <= sh_r[31];
      sh_r <= sh_r << 1;
      cnt_r <= cnt_r - 6'h01;
    end
    else if (go)
    begin
      lreq <= frame[len - 6'h01];
      sh_r <= frame << (6'd33 - len);
      cnt_r <= len - 6'h01;
    end
    else
      lreq <= 1'b0;
  end
endmodule // plrc_link_model

// ==== tb/tb_phy_link_request_config.sv ====
// Self-checking bench for the link request and configuration block.
// Assumes the design, the checker and the link model compile first.
`timescale 1ns/1ps

module tb_phy_link_request_config;
  typedef struct packed {
    logic [2:0] typ;
    logic [2:0] spd;
    logic shrt;
    logic [1:0] exp;
    logic nul;
  } plrc_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [2:0] pins = 3'h6;
  logic bre = 1'b0;
  logic pcl = 1'b0;
  logic pcr = 1'b0;
  logic [5:0] pcg = 6'h00;
  logic rxv = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic [31:0] frm = 32'h0;
  logic [5:0] ln = 6'h00;
  logic go = 1'b0;
  logic busy, lreq, llc_v, arb, pre, fin, stv, brr, hld, acc, mcc, nulact;
  logic [7:0] llc_d, std;
  logic [3:0] sta;
  logic [1:0] asp, sspd, pspd;
  logic [5:0] gap;
  logic [2:0] spwr;
  plrc_pkg::plrc_req_t aty;
  int miscompares = 0;
  int tests_run = 0;
  int n_arb = 0;
  int n_stat = 0;
  int n_pre = 0;
  int n_end = 0;
  int a0, s0, p0, e0;
  plrc_row_t r;
  plrc_row_t rows [9] = '{'{3'h0, 3'h0, 1'b0, 2'h0, 1'b0},
    '{3'h1, 3'h2, 1'b0, 2'h1, 1'b0}, '{3'h2, 3'h4, 1'b0, 2'h2, 1'b0},
    '{3'h3, 3'h1, 1'b0, 2'h0, 1'b0}, '{3'h1, 3'h0, 1'b1, 2'h0, 1'b0},
    '{3'h2, 3'h2, 1'b1, 2'h1, 1'b0}, '{3'h3, 3'h4, 1'b1, 2'h2, 1'b0},
    '{3'h3, 3'h5, 1'b0, 2'h0, 1'b1}, '{3'h0, 3'h7, 1'b0, 2'h0, 1'b1}};

  plrc_top DUT (.clk, .reset, .ce, .lreq, .power_class_pins(pins),
    .bus_reset_event(bre), .phy_config_load(pcl), .phy_config_hold(pcr),
    .phy_config_gap(pcg), .rx_valid(rxv), .rx_data(rxd),
    .llc_rx_valid(llc_v), .llc_rx_data(llc_d), .arb_req(arb),
    .arb_type(aty), .arb_speed(asp), .tx_data_prefix(pre),
    .tx_data_end(fin), .stat_valid(stv), .stat_addr(sta), .stat_data(std),
    .bus_reset_req(brr), .root_holdoff(hld), .gap_count(gap),
    .arbitration_accel_active(acc), .multispeed_concat_enable(mcc),
    .null_packet_actions(nulact), .selfid_pwr(spwr), .selfid_speed(sspd),
    .peer_speed(pspd));

  plrc_link_model link (.clk, .go, .frame(frm), .len(ln), .busy, .lreq);

  // ----------------------------------------------------------------
  // Clock, pulse counting and shared tasks
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;

  // Counts the one-cycle answer pulses as the design raises them.
  always @(posedge clk)
  begin
    n_arb += (arb === 1'b1);
    n_stat += (stv === 1'b1);
    n_pre += (pre === 1'b1);
    n_end += (fin === 1'b1);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hands one frame to the link model and waits for its answer.
  task automatic send(input logic [31:0] f, input logic [5:0] l);
    int k;
    k = 0;
    @(negedge clk);
    frm <= f;
    ln <= l;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (busy && k < 40);
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    send({15'h0, 1'b1, 3'h5, a, d, 1'b0}, 6'd17);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    s0 = n_stat;
    send({23'h0, 1'b1, 3'h4, a, 1'b0}, 6'd9);
    check(n_stat - s0, 1);
    check({sta, std}, {a, exp});
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    #(25 * 8000);
    miscompares++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      r = rows[i];
      a0 = n_arb;
      p0 = n_pre;
      e0 = n_end;
      if (r.shrt)
        send({25'h0, 1'b1, r.typ, r.spd[2:1], 1'b0}, 6'd7);
      else
        send({24'h0, 1'b1, r.typ, r.spd, 1'b0}, 6'd8);
      check(n_arb - a0, !r.nul);
      check(n_pre - p0, r.nul);
      check(n_end - e0, r.nul);
      if (!r.nul)
        check({aty, asp}, {r.typ, r.exp});
    end
    $display("request table done");
    rd(4'h1, 8'h00);
    rd(4'h8, 8'h00);
    check({spwr, sspd, pspd}, {3'h6, 2'h2, 2'h2});
    wr(4'h7, 8'he0);
    rd(4'h8, 8'h02);
    wr(4'h8, 8'h80);
    check({nulact, sspd, pspd}, {1'b1, 2'h0, 2'h2});
    wr(4'h1, 8'h40);
    check({brr, gap}, 7'h40);
    pulse(bre);
    check({brr, sspd}, 3'h0);
    wr(4'h4, 8'h05);
    check(spwr, 3'h5);
    $display("register test done");
    wr(4'h1, 8'hca);
    check({hld, brr, gap}, 8'hca);
    pulse(bre);
    check({brr, gap}, 7'h0a);
    pulse(bre);
    check(gap, 6'h3f);
    pcg = 6'h05;
    pulse(pcl);
    pulse(bre);
    check(gap, 6'h05);
    pulse(bre);
    check(gap, 6'h3f);
    $display("bus reset test done");
    wr(4'h5, 8'h03);
    check({acc, mcc}, 2'h3);
    send(32'h38, 6'd6);
    check(acc, 1'b0);
    send(32'h3a, 6'd6);
    check(acc, 1'b1);
    a0 = n_arb;
    s0 = n_stat;
    send({16'h0, 1'b1, 3'h3, 2'h1, 1'b0, 1'b1, 3'h4, 4'h5, 1'b0}, 6'd16);
    check(n_arb - a0, 1);
    check(n_stat - s0, 1);
    check({asp, sta, std}, {2'h1, 4'h5, 8'h03});
    $display("accel and chained request test done");
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      rxv = i[0];
      rxd = 8'hf0 ^ i[7:0];
      @(negedge clk);
      check({llc_v, llc_d}, {i[0], 8'hf0 ^ i[7:0]});
    end
    ce = 1'b0;
    rxd = 8'h55;
    @(negedge clk);
    check({llc_v, llc_d}, 9'h1f3);
    ce = 1'b1;
    $display("receive forward test done");
    pins = 3'h3;
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check({brr, gap, sspd, spwr}, {1'b0, 6'h00, 2'h2, 3'h3});
    wr(4'h7, 8'he0);
    wr(4'h8, 8'h01);
    check(sspd, 2'h1);
    $display("second reset test done");
    conclude();
  end
endmodule // tb_phy_link_request_config
